/* File: verilog/rps_pkg.sv */
// rps_pkg: constants for the register page control and live status bank.
// assumes one system clock domain; offsets are register addresses within a page.
package rps_pkg;

   // number of control ports: one four-wire and two two-wire
   localparam int          RPS_PORTS            = 3;
   localparam int          RPS_AW               = 8;
   localparam int          RPS_DW               = 8;
   localparam int          RPS_SYNC_STAGES      = 2;

   // register offsets; page control in every page, status in page 0 only
   localparam logic [7:0]  RPS_OFS_PAGE_CTRL    = 8'h00;
   localparam logic [7:0]  RPS_OFS_PAGE_CTRL_HI = 8'h80;
   localparam logic [7:0]  RPS_OFS_STATUS_PRIM  = 8'h01;
   localparam logic [7:0]  RPS_OFS_STATUS_GPI   = 8'h02;

   // page control field positions
   localparam int          RPS_BIT_AUTO_RETURN  = 7;
   localparam int          RPS_BIT_WRITE_MODE   = 6;
   localparam int          RPS_PAGE_MSB         = 2;
   localparam int          RPS_PAGE_LSB         = 0;

   // page select codes
   localparam logic [2:0]  RPS_PAGE_0           = 3'h0;
   localparam logic [2:0]  RPS_PAGE_1           = 3'h1;
   localparam logic [2:0]  RPS_PAGE_2           = 3'h2;
   localparam logic [2:0]  RPS_PAGE_TEST        = 3'h3;

   // primary status and shared input field positions
   localparam int          RPS_BIT_COMPARATOR   = 3;
   localparam int          RPS_BIT_RAMP         = 2;
   localparam int          RPS_BIT_WAKE         = 1;
   localparam int          RPS_BIT_BUTTON       = 0;
   localparam int          RPS_BIT_GPI_SHARED   = 2;

   // reset values
   localparam logic [7:0]  RPS_PAGE_CTRL_RST    = 8'h00;
   localparam logic [7:0]  RPS_DATA_RST         = 8'h00;
   localparam logic [3:0]  RPS_STATUS_RSVD      = 4'h0;

endpackage : rps_pkg

/* File: verilog/rps_page_ctrl.sv */
// rps_page_ctrl: one page control register for one control port.
// assumes req/write/addr/wdata/end come from port logic on the same clock.
`timescale 1ns/10ps
`default_nettype none

module rps_page_ctrl
   import rps_pkg::*;
(
   // clock and reset
   input  wire logic              clock_i,
   input  wire logic              arst_n_i,
   // access from this port
   input  wire logic              req_i,
   input  wire logic              write_i,
   input  wire logic [RPS_AW-1:0] addr_i,
   input  wire logic [RPS_DW-1:0] wdata_i,
   input  wire logic              end_i,
   // register contents
   output logic      [RPS_DW-1:0] page_control_o
);

   logic [RPS_DW-1:0] page_control;
   logic [RPS_DW-1:0] next_page_control;
   logic              ctrl_written;
   logic              next_ctrl_written;
   logic              ctrl_hit;

   // the register answers at 0x00 and 0x80 of every page
   assign ctrl_hit = req_i && write_i &&
                     ((addr_i == RPS_OFS_PAGE_CTRL) || (addr_i == RPS_OFS_PAGE_CTRL_HI));

   // next value; an access that sets up the page is not reverted at its own end
   always_comb begin
      next_page_control = page_control;
      next_ctrl_written = ctrl_written;
      if (ctrl_hit) begin
         next_page_control = wdata_i; // write mode bit stored here
         next_ctrl_written = 1'b1;
      end
      if (end_i) begin
         next_ctrl_written = 1'b0;
         if (page_control[RPS_BIT_AUTO_RETURN] && !ctrl_written && !ctrl_hit) begin
            next_page_control[RPS_PAGE_MSB:RPS_PAGE_LSB] = RPS_PAGE_0;
         end
      end
   end

   // register stage
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         page_control <= RPS_PAGE_CTRL_RST;
         ctrl_written <= 1'b0;
      end else begin
         page_control <= next_page_control;
         ctrl_written <= next_ctrl_written;
      end
   end

   assign page_control_o = page_control;

   a_auto_return: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      end_i && page_control[RPS_BIT_AUTO_RETURN] && !ctrl_written && !ctrl_hit
      |=> page_control_o[RPS_PAGE_MSB:RPS_PAGE_LSB] == RPS_PAGE_0)
      else $error("page not returned to zero after access");

   a_ctrl_store: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      ctrl_hit |=> page_control_o == $past(wdata_i))
      else $error("page control write not stored");

   a_no_return: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      end_i && !page_control[RPS_BIT_AUTO_RETURN] && !ctrl_hit
      |=> $stable(page_control_o))
      else $error("page changed without auto return");

   // the write lands one edge after the hit, so two idle cycles look back two edges
   a_write_mode: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      ctrl_hit ##1 (!ctrl_hit) [*2] |-> page_control_o[RPS_BIT_WRITE_MODE]
      == $past(wdata_i[RPS_BIT_WRITE_MODE], 2))
      else $error("write mode bit lost");

endmodule : rps_page_ctrl

`default_nettype wire

/* File: verilog/rps_register_bank.sv */
// rps_register_bank: page control per port and live status readout.
// assumes each port's serial front end presents decoded one-cycle accesses
// and an end pulse when its transaction has finished.
`timescale 1ns/10ps
`default_nettype none

module rps_register_bank
   import rps_pkg::*;
(
   // clock and reset
   input  wire logic                              clock_i,
   input  wire logic                              arst_n_i,
   // decoded accesses, one lane per control port
   input  wire logic [RPS_PORTS-1:0]              req_i,
   input  wire logic [RPS_PORTS-1:0]              write_i,
   input  wire logic [RPS_PORTS-1:0][RPS_AW-1:0]  addr_i,
   input  wire logic [RPS_PORTS-1:0][RPS_DW-1:0]  wdata_i,
   input  wire logic [RPS_PORTS-1:0]              end_i,
   // answers per port
   output logic      [RPS_PORTS-1:0][RPS_DW-1:0]  rdata_o,
   output logic      [RPS_PORTS-1:0]              ack_o,
   output logic      [RPS_PORTS-1:0][2:0]         page_o,
   output logic      [RPS_PORTS-1:0]              write_mode_o,
   // monitored signals, asynchronous to clock_i
   input  wire logic                              low_threshold_comparator_out_i,
   input  wire logic                              voltage_ramp_active_i,
   input  wire logic                              charger_wakeup_pin_i,
   input  wire logic                              power_button_n_i,
   input  wire logic [7:0]                        general_input_level_i,
   input  wire logic                              analog_input_threshold_i,
   input  wire logic                              threshold_select_i
);

   localparam int NSIG = 14; // six single pins, eight input levels minus none: 1+1+8+1+1+1+1

   logic [NSIG-1:0]                  sync_raw;
   logic [NSIG-1:0]                  sync_a;
   logic [NSIG-1:0]                  sync_b;
   logic [RPS_PORTS-1:0][RPS_DW-1:0] page_control;
   logic [RPS_PORTS-1:0][RPS_DW-1:0] rdata;
   logic [RPS_PORTS-1:0][RPS_DW-1:0] next_rdata;
   logic [RPS_PORTS-1:0]             ack;
   logic [RPS_PORTS-1:0]             next_ack;
   logic [RPS_DW-1:0]                status_primary;
   logic [RPS_DW-1:0]                status_general_inputs_low;
   logic                             s_comp;
   logic                             s_ramp;
   logic                             s_wake;
   logic                             s_button_n;
   logic [7:0]                       s_gpi;
   logic                             s_adc;
   logic                             s_sel;

   // pins come from other domains; two flops before anything reads them
   assign sync_raw = {threshold_select_i, analog_input_threshold_i, general_input_level_i,
                      power_button_n_i, charger_wakeup_pin_i, voltage_ramp_active_i,
                      low_threshold_comparator_out_i};

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sync_a <= '0;
         sync_b <= '0;
      end else begin
         sync_a <= sync_raw;
         sync_b <= sync_a;
      end
   end

   assign {s_sel, s_adc, s_gpi, s_button_n, s_wake, s_ramp, s_comp} = sync_b;

   // status is rebuilt every cycle from the pins, nothing is latched
   always_comb begin
      status_primary                      = {RPS_STATUS_RSVD, 4'h0};
      status_primary[RPS_BIT_COMPARATOR]  = s_comp;
      status_primary[RPS_BIT_RAMP]        = s_ramp;
      status_primary[RPS_BIT_WAKE]        = s_wake;
      status_primary[RPS_BIT_BUTTON]      = !s_button_n;             // pressed is low
      status_general_inputs_low           = s_gpi;
      status_general_inputs_low[RPS_BIT_GPI_SHARED] = s_sel ? s_adc : s_gpi[RPS_BIT_GPI_SHARED];
   end

   // read decode; page control answers in every page
   function automatic logic [RPS_DW-1:0] read_value(
      input logic [RPS_DW-1:0] ctrl,
      input logic [RPS_AW-1:0] addr,
      input logic [RPS_DW-1:0] stat_a,
      input logic [RPS_DW-1:0] stat_b
   );
      logic [2:0] page;
      page = ctrl[RPS_PAGE_MSB:RPS_PAGE_LSB];
      read_value = RPS_DATA_RST;
      if ((addr == RPS_OFS_PAGE_CTRL) || (addr == RPS_OFS_PAGE_CTRL_HI)) begin
         read_value = ctrl;
      end else if (page == RPS_PAGE_0) begin
         if (addr == RPS_OFS_STATUS_PRIM) begin
            read_value = stat_a;
         end else if (addr == RPS_OFS_STATUS_GPI) begin
            read_value = stat_b;
         end
      end
   endfunction : read_value

   // one page control instance per port keeps pages independent
   for (genvar p = 0; p < RPS_PORTS; p++) begin : g_port
      rps_page_ctrl u_page (
         .clock_i        (clock_i),
         .arst_n_i       (arst_n_i),
         .req_i          (req_i[p]),
         .write_i        (write_i[p]),
         .addr_i         (addr_i[p]),
         .wdata_i        (wdata_i[p]),
         .end_i          (end_i[p]),
         .page_control_o (page_control[p])
      );
      assign page_o[p]       = page_control[p][RPS_PAGE_MSB:RPS_PAGE_LSB];
      assign write_mode_o[p] = page_control[p][RPS_BIT_WRITE_MODE];
   end

   // answers: read data captured on the request, writes to status dropped
   always_comb begin
      next_rdata = rdata;
      next_ack   = '0;
      for (int p = 0; p < RPS_PORTS; p++) begin
         if (req_i[p]) begin
            next_ack[p] = 1'b1;
            if (!write_i[p]) begin
               next_rdata[p] = read_value(page_control[p], addr_i[p],
                                          status_primary, status_general_inputs_low);
            end
            // a write to 0x01 or 0x02 touches nothing here
         end
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata <= '0;
         ack   <= '0;
      end else begin
         rdata <= next_rdata;
         ack   <= next_ack;
      end
   end

   assign rdata_o = rdata;
   assign ack_o   = ack;

   a_status_live: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      req_i[0] && !write_i[0] && addr_i[0] == RPS_OFS_STATUS_PRIM && page_o[0] == RPS_PAGE_0
      |=> rdata_o[0] == $past(status_primary))
      else $error("status read not current");

   a_button_pol: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      ##2 status_primary[RPS_BIT_BUTTON] == !$past(power_button_n_i, 2))
      else $error("button bit polarity wrong");

   a_ramp_follow: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      ##2 status_primary[RPS_BIT_RAMP] == $past(voltage_ramp_active_i, 2))
      else $error("ramp bit does not follow pin");

   a_comp_rsvd: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      ##2 status_primary[7:4] == 4'h0 &&
      status_primary[RPS_BIT_COMPARATOR] == $past(low_threshold_comparator_out_i, 2))
      else $error("comparator or reserved bits wrong");

   a_gpi_shared: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      ##2 status_general_inputs_low[RPS_BIT_GPI_SHARED] == ($past(threshold_select_i, 2) ?
      $past(analog_input_threshold_i, 2) : $past(general_input_level_i[2], 2)))
      else $error("shared input bit wrong");

   a_port_isol: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      req_i[0] && !req_i[1] && !end_i[1] |=> $stable(page_o[1]))
      else $error("port one page moved by port zero");

   a_page_gate: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      req_i[1] && !write_i[1] && addr_i[1] == RPS_OFS_STATUS_GPI && page_o[1] != RPS_PAGE_0
      |=> rdata_o[1] == RPS_DATA_RST)
      else $error("status visible outside page zero");

   a_ack_timing: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      req_i[2] |=> ack_o[2] ##1 (ack_o[2] == $past(req_i[2])))
      else $error("ack not one cycle after request");

   // wake pin reaches its bit unchanged, two edges late through the synchroniser
   a_wake_follow: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      ##2 status_primary[RPS_BIT_WAKE] == $past(charger_wakeup_pin_i, 2))
      else $error("wake bit does not follow pin");

   // upper input levels are plain copies, no inversion
   a_gpi_levels: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      ##2 status_general_inputs_low[7:3] == $past(general_input_level_i[7:3], 2))
      else $error("input level bits wrong");

   // either alias of the page control reads back the stored byte
   a_ctrl_read: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      req_i[1] && !write_i[1] &&
      (addr_i[1] == RPS_OFS_PAGE_CTRL || addr_i[1] == RPS_OFS_PAGE_CTRL_HI)
      |=> rdata_o[1] == $past(page_control[1]))
      else $error("page control read back wrong");

   // a write aimed at a status offset must not reach the page control
   a_status_ro: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      req_i[0] && write_i[0] && !end_i[0] &&
      (addr_i[0] == RPS_OFS_STATUS_PRIM || addr_i[0] == RPS_OFS_STATUS_GPI)
      |=> $stable(page_control[0]))
      else $error("status write changed page control");

   // read data only moves on a read; writes leave it alone
   a_rdata_hold: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      !(req_i[0] && !write_i[0]) |=> $stable(rdata_o[0]))
      else $error("read data moved without a read");

endmodule : rps_register_bank

`default_nettype wire

/* File: tb/rps_host_model.sv */
// rps_host_model: host processor on the three decoded control lanes.
// assumes the bank takes req on an edge and acks one cycle later.
`timescale 1ns/10ps
`default_nettype none

module rps_host_model
   import rps_pkg::*;
(
   // clock
   input  wire logic                              clock_i,
   // access lanes
   output logic      [RPS_PORTS-1:0]              req_o,
   output logic      [RPS_PORTS-1:0]              write_o,
   output logic      [RPS_PORTS-1:0][RPS_AW-1:0]  addr_o,
   output logic      [RPS_PORTS-1:0][RPS_DW-1:0]  wdata_o,
   output logic      [RPS_PORTS-1:0]              end_o,
   // answers
   input  wire logic [RPS_PORTS-1:0]              ack_i,
   input  wire logic [RPS_PORTS-1:0][RPS_DW-1:0]  rdata_i
);
   // edges waited for the last ack; the bench compares it
   int ack_wait;

   // idle lanes at time zero
   initial begin
      ack_wait = 0;
      req_o   = '0;
      write_o = '0;
      addr_o  = '0;
      wdata_o = '0;
      end_o   = '0;
   end

   // one byte access; last marks the end of the serial transaction
   task automatic xfer(input int ln, input logic wr, input logic [7:0] a,
                       input logic [7:0] d, input logic last, output logic [7:0] rd);
      int n;
      @(posedge clock_i);
      req_o[ln]   <= 1'b1;
      write_o[ln] <= wr;
      addr_o[ln]  <= a;
      wdata_o[ln] <= d;
      end_o[ln]   <= last;
      @(posedge clock_i);
      req_o[ln]   <= 1'b0;
      end_o[ln]   <= 1'b0;
      // released address and data lines do not keep their last value
      addr_o[ln]  <= ~a;
      wdata_o[ln] <= ~d;
      n = 0;
      while (ack_i[ln] !== 1'b1 && n < 8) begin
         @(posedge clock_i);
         n++;
      end
      ack_wait = n;
      rd = rdata_i[ln];
   endtask : xfer
endmodule : rps_host_model
`default_nettype wire

/* File: tb/testbench.sv */
// testbench: page control per lane and live status readout of the bank.
// assumes status pins reach the registers two edges after they change.
`timescale 1ns/10ps
`default_nettype none

module testbench;
   import rps_pkg::*;
   logic                             clock_i, arst_n_i, comp, ramp, wake, btn_n, adc, sel;
   logic [7:0]                       gpi, rd;
   logic [RPS_PORTS-1:0]             req, wr, fin, ack, wmode;
   logic [RPS_PORTS-1:0][7:0]        addr, wdata, rdata;
   logic [RPS_PORTS-1:0][2:0]        page;
   int                               err_total, total_checks;

   rps_register_bank rps_register_bank_inst (.clock_i(clock_i), .arst_n_i(arst_n_i),
      .req_i(req), .write_i(wr), .addr_i(addr), .wdata_i(wdata), .end_i(fin),
      .rdata_o(rdata), .ack_o(ack), .page_o(page), .write_mode_o(wmode),
      .low_threshold_comparator_out_i(comp), .voltage_ramp_active_i(ramp),
      .charger_wakeup_pin_i(wake), .power_button_n_i(btn_n),
      .general_input_level_i(gpi), .analog_input_threshold_i(adc),
      .threshold_select_i(sel));
   rps_host_model rps_host_model_inst (.clock_i(clock_i), .req_o(req), .write_o(wr),
      .addr_o(addr), .wdata_o(wdata), .end_o(fin), .ack_i(ack), .rdata_i(rdata));

   // 100 MHz system clock
   always #5 clock_i = ~clock_i;

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic give_verdict();
      if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict

   // every page code lands in the page field of lane 0 only
   task automatic t_page_codes();
      for (int c = 0; c < 4; c++) begin
         rps_host_model_inst.xfer(0, 1'b1, 8'h00, 8'(c), 1'b0, rd);
         check({5'h00, page[0]}, 8'(c));
      end
      rps_host_model_inst.xfer(0, 1'b1, 8'h00, 8'h00, 1'b0, rd);
   endtask : t_page_codes

   // upper alias on lane 1, other lanes untouched, mode bit out
   task automatic t_port_split();
      rps_host_model_inst.xfer(1, 1'b1, 8'h80, 8'h43, 1'b0, rd);
      check({5'h00, page[1]}, 8'h03);
      check({7'h00, wmode[1]}, 8'h01);
      check({2'h0, page[0], page[2]}, 8'h00);
      rps_host_model_inst.xfer(1, 1'b0, 8'h00, 8'h00, 1'b0, rd);
      check(rd, 8'h43);
      rps_host_model_inst.xfer(1, 1'b0, 8'h01, 8'h00, 1'b0, rd);
      check(rd, 8'h00);
      rps_host_model_inst.xfer(1, 1'b0, 8'h02, 8'h00, 1'b1, rd);
      check(rd, 8'h00);
      check({5'h00, page[1]}, 8'h03);
   endtask : t_port_split

   // page falls back to zero after the next finished access, mode bits kept
   task automatic t_auto_return();
      rps_host_model_inst.xfer(2, 1'b1, 8'h00, 8'h82, 1'b1, rd);
      check({5'h00, page[2]}, 8'h02);
      check({7'h00, wmode[2]}, 8'h00);
      rps_host_model_inst.xfer(2, 1'b0, 8'h01, 8'h00, 1'b1, rd);
      check({5'h00, page[2]}, 8'h00);
      rps_host_model_inst.xfer(2, 1'b0, 8'h00, 8'h00, 1'b0, rd);
      check(rd, 8'h80);
   endtask : t_auto_return

   // pins change each round; reads must follow them, polarity kept
   task automatic t_status(input logic poke);
      logic [7:0] ea, eb;
      for (int v = 0; v < 4; v++) begin
         @(posedge clock_i);
         comp  <= v[0];
         ramp  <= ~v[0];
         wake  <= v[1];
         btn_n <= v[0] ^ v[1];
         gpi   <= v[0] ? 8'ha5 : 8'h5a;
         adc   <= v[1];
         sel   <= v[0];
         repeat (4) @(posedge clock_i);
         ea = {4'h0, comp, ramp, wake, ~btn_n};
         eb = sel ? {gpi[7:3], adc, gpi[1:0]} : gpi;
         if (poke) rps_host_model_inst.xfer(0, 1'b1, 8'h01, 8'hff, 1'b0, rd);
         if (poke) rps_host_model_inst.xfer(0, 1'b1, 8'h02, ~eb, 1'b0, rd);
         if (poke) check(8'(rps_host_model_inst.ack_wait), 8'h01);
         rps_host_model_inst.xfer(0, 1'b0, 8'h01, 8'h00, 1'b0, rd);
         check(rd, ea);
         rps_host_model_inst.xfer(0, 1'b0, 8'h02, 8'h00, 1'b0, rd);
         check(rd, eb);
      end
      check({5'h00, page[0]}, 8'h00);
   endtask : t_status

   // watchdog far beyond the expected run length
   initial begin
      repeat (3000) @(posedge clock_i);
      err_total++;
      give_verdict();
   end

   // reset, then scenarios in sequence
   initial begin
      clock_i      = 1'b0;
      arst_n_i     = 1'b0;
      {comp, ramp, wake, btn_n, adc, sel} = 6'h00;
      gpi          = 8'h00;
      err_total    = 0;
      total_checks = 0;
      repeat (5) @(posedge clock_i);
      arst_n_i <= 1'b1;
      check({2'h0, page[0], page[1]}, 8'h00);
      check({5'h00, wmode}, 8'h00);
      t_page_codes();
      t_port_split();
      t_auto_return();
      t_status(1'b0);
      t_status(1'b1);
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
